/* File: ctm_pkg.sv */
package ctm_pkg;

  // Register word index on the byte-wide register port.
  localparam logic [2:0] ADDR_CONTROL_0 = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_1 = 3'h1;
  localparam logic [2:0] ADDR_COUNT_LOW = 3'h2;
  localparam logic [2:0] ADDR_COUNT_HIGH = 3'h3;
  localparam logic [2:0] ADDR_COMPARE_A_LOW = 3'h4;
  localparam logic [2:0] ADDR_COMPARE_A_HIGH = 3'h5;

  // Widths of the counter, the period code and the bus.
  localparam int COUNT_W = 10;
  localparam int PERIOD_W = 3;
  localparam int LOW_W = 7;
  localparam int DATA_W = 8;
  localparam int HIGH_W = COUNT_W - DATA_W;

  // Reset and constant values.
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 10'h000;
  localparam logic [COUNT_W:0] COUNT_ONE = 11'h001;
  localparam logic [LOW_W-1:0] LOW_ZERO = 7'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-HIGH_W-1:0] HIGH_PAD = 6'h00;

  // Prescaler terminal counts.
  localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
  localparam logic [5:0] HIGH_DIV_ZERO = 6'h00;
  localparam logic [3:0] HIGH_DIV16_LAST = 4'hF;
  localparam logic [5:0] HIGH_DIV64_LAST = 6'h3F;

  // Counter clock source codes.
  localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CK_SUB_A = 3'h4;
  localparam logic [2:0] CK_SUB_B = 3'h5;
  localparam logic [2:0] CK_EXT_RISE = 3'h6;
  localparam logic [2:0] CK_EXT_FALL = 3'h7;

  // Operating modes.
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;

  // Pin actions; compare mode and PWM mode share the codes.
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] PWM_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_ACTIVE = 2'h1;
  localparam logic [1:0] PWM_WAVE = 2'h2;

  // Synchroniser bit positions of the sampled clock inputs.
  localparam int SRC_HIGH = 0;
  localparam int SRC_SUB = 1;
  localparam int SRC_EXT = 2;
  localparam logic [2:0] SYNC_ZERO = 3'h0;

  // Control register 0, bit 7 down to bit 0.
  typedef struct packed {
    logic       count_pause;
    logic [2:0] clock_select;
    logic       counter_on;
    logic [2:0] period_code;
  } control_0_s;

  // Control register 1, bit 7 down to bit 0.
  typedef struct packed {
    logic [1:0] mode_select;
    logic [1:0] pin_action;
    logic       output_initial_level;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_source_select;
  } control_1_s;

  localparam control_0_s CONTROL_0_RESET = 8'h00;
  localparam control_1_s CONTROL_1_RESET = 8'h00;

endpackage : ctm_pkg

/* File: compact_timer.sv */
// Chosen here: the register offsets and the plain strobed port.
module compact_timer (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic [2:0]                  reg_addr,
  input  wire logic [ctm_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [ctm_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        high_clock_in,
  input  wire logic                        sub_clock_in,
  input  wire logic                        ext_clock_in,
  output logic                             match_a_irq,
  output logic                             match_p_irq,
  output logic                             timer_out,
  output logic                             timer_out_n
);
  import ctm_pkg::*;

  control_0_s          ctrl0_q;
  control_1_s          ctrl1_q;
  logic [COUNT_W-1:0]  count_q;
  logic [COUNT_W-1:0]  compare_a_q;
  logic [DATA_W-1:0]   hold_buf_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                on_prev_q;
  logic [2:0]          sync1_q;
  logic [2:0]          sync2_q;
  logic [2:0]          sync3_q;
  logic [1:0]          sys_div_q;
  logic [5:0]          high_div_q;
  logic                irq_a_q;
  logic                irq_p_q;
  logic                pin_q;
  logic                out_q;
  logic                out_n_q;
  logic                src_edge;
  logic                high_edge;
  logic                tick;
  logic                on_rise;
  logic [COUNT_W:0]    count_inc;
  logic                match_a;
  logic                match_p;
  logic                clear_now;
  logic                pwm_level;
  logic [COUNT_W-1:0]  duty_value;
  logic                wr_c0;
  logic                wr_c1;
  logic                wr_al;
  logic                wr_ah;
  logic                rd_dh;
  logic                rd_ah;

  // Register port decode.
  assign wr_c0 = reg_write && (reg_addr == ADDR_CONTROL_0);
  assign wr_c1 = reg_write && (reg_addr == ADDR_CONTROL_1);
  assign wr_al = reg_write && (reg_addr == ADDR_COMPARE_A_LOW);
  assign wr_ah = reg_write && (reg_addr == ADDR_COMPARE_A_HIGH);
  assign rd_dh = reg_read && (reg_addr == ADDR_COUNT_HIGH);
  assign rd_ah = reg_read && (reg_addr == ADDR_COMPARE_A_HIGH);

  // Control registers; bit 7 of control 0 is the pause bit.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl0_q <= CONTROL_0_RESET;
      ctrl1_q <= CONTROL_1_RESET;
    end
    else
    begin
      if (wr_c0)
        ctrl0_q <= control_0_s'(reg_wdata);
      if (wr_c1)
        ctrl1_q <= control_1_s'(reg_wdata);
    end
  end

  // Compare A pair and the shared low byte buffer.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      compare_a_q <= COUNT_ZERO;
      hold_buf_q  <= BYTE_ZERO;
    end
    else
    begin
      if (wr_al)
        hold_buf_q <= reg_wdata;
      else if (rd_dh)
        hold_buf_q <= count_q[DATA_W-1:0];
      else if (rd_ah)
        hold_buf_q <= compare_a_q[DATA_W-1:0];
      if (wr_ah)
        compare_a_q <= {reg_wdata[HIGH_W-1:0], hold_buf_q};
    end
  end

  // Read data appear the cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= BYTE_ZERO;
    else if (reg_read)
    begin
      case (reg_addr)
        ADDR_CONTROL_0:      rdata_q <= ctrl0_q;
        ADDR_CONTROL_1:      rdata_q <= ctrl1_q;
        ADDR_COUNT_LOW:      rdata_q <= hold_buf_q;
        ADDR_COUNT_HIGH:     rdata_q <= {HIGH_PAD, count_q[COUNT_W-1:DATA_W]};
        ADDR_COMPARE_A_LOW:  rdata_q <= hold_buf_q;
        ADDR_COMPARE_A_HIGH: rdata_q <= {HIGH_PAD, compare_a_q[COUNT_W-1:DATA_W]};
        default:             rdata_q <= BYTE_ZERO;
      endcase
    end
    else
      rdata_q <= BYTE_ZERO;
  end

  // Two-stage synchronisers plus one history stage for edge detection.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= SYNC_ZERO;
      sync2_q <= SYNC_ZERO;
      sync3_q <= SYNC_ZERO;
    end
    else
    begin
      sync1_q <= {ext_clock_in, sub_clock_in, high_clock_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign high_edge = sync2_q[SRC_HIGH] && !sync3_q[SRC_HIGH];

  // Prescalers for the system clock and the internal high clock.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sys_div_q  <= SYS_DIV4_LAST;
      high_div_q <= HIGH_DIV_ZERO;
    end
    else
    begin
      sys_div_q <= sys_div_q + 2'h1;
      if (high_edge)
        high_div_q <= high_div_q + 6'h01;
    end
  end

  // Counter clock source selection.
  always_comb
  begin
    case (ctrl0_q.clock_select)
      CK_SYS_DIV4:   src_edge = (sys_div_q == SYS_DIV4_LAST);
      CK_SYS:        src_edge = 1'b1;
      CK_HIGH_DIV16: src_edge = high_edge && (high_div_q[3:0] == HIGH_DIV16_LAST);
      CK_HIGH_DIV64: src_edge = high_edge && (high_div_q == HIGH_DIV64_LAST);
      CK_SUB_A,
      CK_SUB_B:      src_edge = sync2_q[SRC_SUB] && !sync3_q[SRC_SUB];
      CK_EXT_RISE:   src_edge = sync2_q[SRC_EXT] && !sync3_q[SRC_EXT];
      CK_EXT_FALL:   src_edge = !sync2_q[SRC_EXT] && sync3_q[SRC_EXT];
      default:       src_edge = 1'b0;
    endcase
  end

  // Counting is gated by the on bit and the pause bit.
  assign tick    = src_edge && ctrl0_q.counter_on && !ctrl0_q.count_pause;
  assign on_rise = ctrl0_q.counter_on && !on_prev_q;

  // Comparators; P matches when the next count reaches code times 128, or 1024 for code 0.
  assign count_inc = {1'b0, count_q} + COUNT_ONE;
  assign match_a   = (count_q == compare_a_q);
  assign match_p   = (count_inc[COUNT_W-1:LOW_W] == ctrl0_q.period_code)
                     && (count_inc[LOW_W-1:0] == LOW_ZERO);

  // Clear source: PWM takes A if period_duty_swap else the period comparator; other modes use clear_source_select.
  always_comb
  begin
    if (ctrl1_q.mode_select == MODE_PWM)
      clear_now = ctrl1_q.period_duty_swap ? match_a : match_p;
    else
      clear_now = ctrl1_q.clear_source_select ? match_a : match_p;
  end

  // The counter itself.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      count_q   <= COUNT_ZERO;
      on_prev_q <= 1'b0;
    end
    else
    begin
      on_prev_q <= ctrl0_q.counter_on;
      if (on_rise)
        count_q <= COUNT_ZERO;
      else if (tick && clear_now)
        count_q <= COUNT_ZERO;
      else if (tick)
        count_q <= count_inc[COUNT_W-1:0];
    end
  end

  // Interrupt request pulses, one per comparator.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_a_q <= 1'b0;
      irq_p_q <= 1'b0;
    end
    else
    begin
      irq_a_q <= tick && !on_rise && match_a;
      irq_p_q <= tick && !on_rise && match_p;
    end
  end

  // PWM level: with PWM_WAVE, active while the count is below the duty value.
  assign duty_value = ctrl1_q.period_duty_swap
                      ? {ctrl0_q.period_code, LOW_ZERO} : compare_a_q;
  always_comb
  begin
    case (ctrl1_q.pin_action)
      PWM_INACTIVE: pwm_level = !ctrl1_q.output_initial_level;
      PWM_ACTIVE:   pwm_level = ctrl1_q.output_initial_level;
      PWM_WAVE:     pwm_level = (count_q < duty_value)
                                ? ctrl1_q.output_initial_level
                                : !ctrl1_q.output_initial_level;
      default:      pwm_level = pin_q;
    endcase
  end

  // Raw output state before the polarity control.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      pin_q <= 1'b0;
    else if (ctrl1_q.mode_select == MODE_COMPARE)
    begin
      if (on_rise)
        pin_q <= ctrl1_q.output_initial_level;
      else if (tick && match_a)
      begin
        case (ctrl1_q.pin_action)
          ACT_LOW:    pin_q <= 1'b0;
          ACT_HIGH:   pin_q <= 1'b1;
          ACT_TOGGLE: pin_q <= !pin_q;
          default:    pin_q <= pin_q;
        endcase
      end
    end
    else if (ctrl1_q.mode_select == MODE_PWM)
      pin_q <= pwm_level;
  end

  // Registered pins; the complement is always the inverse.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      out_q   <= 1'b0;
      out_n_q <= 1'b1;
    end
    else if (ctrl1_q.mode_select == MODE_TIMER)
    begin
      out_q   <= pin_q;
      out_n_q <= !pin_q;
    end
    else
    begin
      out_q   <= pin_q ^ ctrl1_q.output_invert;
      out_n_q <= !(pin_q ^ ctrl1_q.output_invert);
    end
  end

  assign reg_rdata   = rdata_q;
  assign match_a_irq = irq_a_q;
  assign match_p_irq = irq_p_q;
  assign timer_out   = out_q;
  assign timer_out_n = out_n_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence low_write_s;
    reg_write && (reg_addr == ADDR_COMPARE_A_LOW);
  endsequence

  sequence high_write_s;
    reg_write && (reg_addr == ADDR_COMPARE_A_HIGH);
  endsequence

  sequence high_read_s;
    reg_read && (reg_addr == ADDR_COUNT_HIGH);
  endsequence

  sequence low_read_s;
    reg_read && (reg_addr == ADDR_COUNT_LOW);
  endsequence

  a_count_advance: assert property (
    tick && !clear_now && !on_rise |=> count_q == $past(count_q) + 10'h001)
    else $error("Counter did not advance on a tick.");

  a_count_frozen: assert property (
    !tick && !on_rise |=> $stable(count_q))
    else $error("Counter moved without a tick.");

  a_on_clears: assert property (
    $rose(ctrl0_q.counter_on) |=> count_q == COUNT_ZERO)
    else $error("Counter not cleared when switched on.");

  a_p_clear_irq: assert property (
    tick && match_p && !on_rise && !ctrl1_q.clear_source_select
    && ctrl1_q.mode_select != MODE_PWM |=> count_q == COUNT_ZERO && irq_p_q)
    else $error("Comparator P match did not clear and flag.");

  a_a_irq: assert property (
    irq_a_q |-> $past(count_q) == $past(compare_a_q) && $past(tick))
    else $error("Comparator A request without a match.");

  a_out_compl: assert property (
    timer_out_n == !timer_out)
    else $error("Complementary output is not the inverse.");

  a_buf_write: assert property (
    low_write_s ##1 high_write_s |=> compare_a_q[DATA_W-1:0] == $past(reg_wdata, 2))
    else $error("Buffered low byte not committed.");

  a_buf_read: assert property (
    high_read_s ##1 low_read_s |=> reg_rdata == $past(count_q[DATA_W-1:0], 2))
    else $error("Low byte read did not return latched value.");

  a_low_hold: assert property (
    low_write_s |=> $stable(compare_a_q))
    else $error("Low byte write changed compare value directly.");

  a_toggle_pin: assert property (
    ctrl1_q.mode_select == MODE_COMPARE && ctrl1_q.pin_action == ACT_TOGGLE
    && tick && match_a && !on_rise |=> pin_q != $past(pin_q))
    else $error("Output did not toggle on compare match.");

endmodule : compact_timer

/* File: ctm_clock_source.sv */
module ctm_clock_source (
  input  wire logic clock,
  output logic      high_clock_in,
  output logic      sub_clock_in,
  output logic      ext_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] div_q = 5'h00;

  // The internal high and sub clocks run free as slow square waves.
  always @(posedge clock)
  begin
    div_q         <= div_q + 5'h01;
    high_clock_in <= div_q[2];
    sub_clock_in  <= div_q[4];
  end

  // The event pin only moves when the bench asks for edges; otherwise it holds its level.
  initial
  begin
    ext_clock_in = 1'b0;
  end

  // Toggles the event pin n times, eight cycles apart, so the synchroniser never misses one.
  task automatic edges(input int n);
    repeat (n)
    begin
      repeat (8) @(posedge clock);
      ext_clock_in <= ~ext_clock_in;
    end
    repeat (8) @(posedge clock);
  endtask : edges

endmodule : ctm_clock_source

/* File: tb_compact_timer_module.sv */
module tb_compact_timer_module;
  timeunit 1ns;
  timeprecision 1ps;
  import ctm_pkg::*;

  logic       clock, resetn, reg_write, reg_read;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, hi, lo;
  logic       high_clock_in, sub_clock_in, ext_clock_in;
  logic       match_a_irq, match_p_irq, timer_out, timer_out_n, ini, inv;
  logic [9:0] cv, ca, cb;
  logic [1:0] act;
  int         num_errors, total_checks, seed, n, i, v;

  compact_timer dut (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .high_clock_in(high_clock_in), .sub_clock_in(sub_clock_in),
    .ext_clock_in(ext_clock_in), .match_a_irq(match_a_irq), .match_p_irq(match_p_irq),
    .timer_out(timer_out), .timer_out_n(timer_out_n)
  );

  ctm_clock_source src (
    .clock(clock), .high_clock_in(high_clock_in), .sub_clock_in(sub_clock_in),
    .ext_clock_in(ext_clock_in)
  );

  // The system clock toggles every half period.
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the data are taken in the following cycle only.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Writes the compare value low byte first, then the committing high byte with no gap.
  task automatic wr_cmp(input logic [9:0] c);
    @(posedge clock);
    reg_addr  <= ADDR_COMPARE_A_LOW;
    reg_wdata <= c[7:0];
    reg_write <= 1'b1;
    @(posedge clock);
    reg_addr  <= ADDR_COMPARE_A_HIGH;
    reg_wdata <= {6'h00, c[9:8]};
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr_cmp

  // Reads the count high byte, then the low byte in the very next cycle.
  task automatic rd_count(output logic [9:0] c);
    @(posedge clock);
    reg_addr <= ADDR_COUNT_HIGH;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_addr <= ADDR_COUNT_LOW;
    #1 hi = reg_rdata;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 lo = reg_rdata;
    c = {hi[1:0], lo};
  endtask : rd_count

  // Bench clock cycles per tick of each internal source except the undivided system clock, from the clock model's dividers.
  function automatic int src_div(input int code);
    case (code)
      0:       return 4;
      2:       return 128;
      3:       return 512;
      default: return 32;
    endcase
  endfunction : src_div

  function automatic logic hit(input int sel);
    return (sel == 1) ? match_a_irq : match_p_irq;
  endfunction : hit

  // Waits for the selected match pulse under a bound.
  task automatic wait_irq(input int sel);
    for (int k = 0; k < 3000 && hit(sel) !== 1'b1; k++) @(negedge clock);
  endtask : wait_irq

  // Measures the cycles between two consecutive pulses of one match request.
  task automatic irq_gap(input int sel, output int g);
    wait_irq(sel);
    @(negedge clock);
    g = 1;
    while (hit(sel) !== 1'b1 && g < 3000)
    begin
      @(negedge clock);
      g++;
    end
  endtask : irq_gap

  // Period of the P match in timer clocks for a period code.
  function automatic int p_period(input int code);
    return (code == 0) ? 1024 : code * 128;
  endfunction : p_period

  // Pin level after an A match in compare mode, before inversion.
  function automatic logic cmp_level(input logic [1:0] a, input logic start);
    case (a)
      ACT_LOW:  return 1'b0;
      ACT_HIGH: return 1'b1;
      ACT_TOGGLE: return ~start;
      default:  return start;
    endcase
  endfunction : cmp_level

  task automatic tally_and_finish();
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // The complementary pin is watched on every cycle out of reset.
  always @(negedge clock)
  begin
    if (resetn === 1'b1) chk(timer_out_n, {~timer_out});
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (60000) @(posedge clock);
    num_errors++;
    tally_and_finish();
  end

  // Main sequence.
  initial
  begin
    seed = 32'hf904908d;
    num_errors = 0;
    total_checks = 0;
    resetn = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rd(ADDR_CONTROL_0, lo);
    chk(lo, 11'h000);
    rd(ADDR_CONTROL_1, lo);
    chk(lo, 11'h000);
    rd(3'h6, lo);
    chk(lo, 11'h000);
    rd(ADDR_COUNT_HIGH, lo);
    chk(lo, 11'h000);
    cv = 10'($random(seed));
    wr_cmp(cv);
    wr(ADDR_COMPARE_A_LOW, ~cv[7:0]);
    rd(ADDR_COMPARE_A_HIGH, hi);
    rd(ADDR_COMPARE_A_LOW, lo);
    chk(hi, {3'h0, 6'h00, cv[9:8]});
    chk({hi[1:0], lo}, cv);
    wr(ADDR_CONTROL_1, {MODE_TIMER, ACT_NONE, 4'h0});
    for (i = 0; i < 3; i++)
    begin
      v = (i == 2) ? 0 : 2 * i + 1;
      wr(ADDR_CONTROL_0, 8'h00);
      wr(ADDR_CONTROL_0, {1'b0, CK_SYS, 1'b1, 3'(v)});
      irq_gap(0, n);
      chk(11'(n), 11'(p_period(v)));
    end
    wr(ADDR_CONTROL_0, 8'h00);
    wr_cmp(10'h001);
    wr(ADDR_CONTROL_1, {MODE_TIMER, ACT_NONE, 4'h1});
    for (i = 0; i < 5; i++)
    begin
      v = (i == 0) ? 0 : i + 1;
      wr(ADDR_CONTROL_0, 8'h00);
      wr(ADDR_CONTROL_0, {1'b0, 3'(v), 1'b1, 3'h0});
      irq_gap(1, n);
      chk(11'(n), 11'(2 * src_div(v)));
    end
    wr(ADDR_CONTROL_0, 8'h00);
    cv = 10'd16 + 10'($random(seed) & 255);
    wr_cmp(cv);
    wr(ADDR_CONTROL_1, {MODE_TIMER, ACT_NONE, 4'h1});
    wr(ADDR_CONTROL_0, {1'b0, CK_SYS, 1'b1, 3'h0});
    irq_gap(1, n);
    chk(11'(n), {1'b0, cv} + 11'h001);
    wr(ADDR_CONTROL_0, {1'b1, CK_SYS, 1'b1, 3'h0});
    rd_count(ca);
    repeat (30) @(posedge clock);
    rd_count(cb);
    chk(cb, ca);
    wr(ADDR_CONTROL_0, {1'b0, CK_SYS, 1'b0, 3'h0});
    rd_count(ca);
    repeat (30) @(posedge clock);
    rd_count(cb);
    chk(cb, ca);
    wr(ADDR_CONTROL_0, {1'b0, CK_SYS, 1'b1, 3'h0});
    rd_count(cb);
    chk({cb < 10'd8}, 11'h001);
    for (act = ACT_LOW; act != ACT_NONE; act++)
    begin
      ini = (act != ACT_HIGH);
      inv = (act == ACT_LOW);
      wr(ADDR_CONTROL_0, 8'h00);
      wr(ADDR_CONTROL_1, {MODE_COMPARE, act, ini, inv, 2'b01});
      wr(ADDR_CONTROL_0, {1'b0, CK_SYS, 1'b1, 3'h0});
      repeat (3) @(negedge clock);
      chk(timer_out, {ini ^ inv});
      wait_irq(1);
      repeat (3) @(negedge clock);
      chk(timer_out, {cmp_level(act, ini) ^ inv});
    end
    wr(ADDR_CONTROL_0, 8'h00);
    cv = 10'd8 + 10'($random(seed) & 63);
    wr_cmp(cv);
    wr(ADDR_CONTROL_1, {MODE_PWM, PWM_WAVE, 4'h8});
    wr(ADDR_CONTROL_0, {1'b0, CK_SYS, 1'b1, 3'h1});
    wait_irq(0);
    n = 0;
    repeat (128)
    begin
      @(negedge clock);
      if (timer_out === 1'b1) n++;
    end
    chk(11'(n), {1'b0, cv});
    wr(ADDR_CONTROL_0, 8'h00);
    wr(ADDR_CONTROL_1, {MODE_TIMER, ACT_NONE, 4'h0});
    wr(ADDR_CONTROL_0, {1'b0, CK_EXT_RISE, 1'b1, 3'h0});
    v = 3 + ($random(seed) & 7);
    src.edges(2 * v - 1);
    rd_count(ca);
    chk(ca, 11'(v));
    wr(ADDR_CONTROL_0, 8'h00);
    wr(ADDR_CONTROL_0, {1'b0, CK_EXT_FALL, 1'b1, 3'h0});
    v = 3 + ($random(seed) & 7);
    src.edges(2 * v - 1);
    rd_count(ca);
    chk(ca, 11'(v));
    wr(ADDR_CONTROL_0, {1'b0, CK_EXT_FALL, 1'b0, 3'h0});
    wr(ADDR_COUNT_LOW, 8'hFF);
    wr(ADDR_COUNT_HIGH, 8'h03);
    wr(3'h7, 8'hAA);
    rd_count(cb);
    chk(cb, ca);
    rd(ADDR_CONTROL_0, lo);
    chk(lo, {3'h0, 1'b0, CK_EXT_FALL, 1'b0, 3'h0});
    tally_and_finish();
  end

endmodule : tb_compact_timer_module
